// file: hdl/etc_regs.svh
// What this block does
// - eight-bit counter and two compare registers
// - bottom when counter becomes zero
// - maximum when counter becomes 0xff
// - top is 0xff or compare a
// - clock select picks prescaled tick or pin
// - select zero stops all ticks
// - counter readable and writable any time
// - counter write beats count and clear
// - three-bit mode split over two controls
// - overflow flag set per mode, interrupts
// - flags visible, requests gated by mask
// - match sets compare flag next tick
// - flag clears on service or write-one
// - compare buffered only in pwm modes
// - buffer copies at top only
// - cpu reaches buffer or active register
// - force strobe acts like match in non-pwm modes only, no flag
// - counter write blocks matches next tick
// - output state kept across mode change
// - output action change acts immediately
// - module runs only while power bit zero
// - mode 0 counts up, overflow at zero
// - mode 2 clears on compare a match
// - modes 3 and 7 fast pwm
// - action zero leaves output unchanged
`ifndef ETC_REGS_SVH
`define ETC_REGS_SVH
// ****************************************
// register indexes
// ****************************************
`define ETC_A_CTRL_A 4'h0
`define ETC_A_CTRL_B 4'h1
`define ETC_A_COUNT 4'h2
`define ETC_A_CMP_A 4'h3
`define ETC_A_CMP_B 4'h4
`define ETC_A_MASK 4'h5
`define ETC_A_FLAGS 4'h6
`define ETC_A_POWER 4'h7
// ****************************************
// values and fields
// ****************************************
`define ETC_BOTTOM 8'h00
`define ETC_MAX 8'hff
`define ETC_ZERO8 8'h00
`define ETC_CS_OFF 3'h0
`define ETC_CS_FALL 3'h6
`define ETC_CS_RISE 3'h7
`define ETC_M_NORMAL 3'h0
`define ETC_M_CTC 3'h2
`define ETC_M_FAST 3'h3
`define ETC_M_FAST_A 3'h7
`define ETC_M_PHASE_LO 2'h1
`define ETC_ACT_NONE 2'h0
`define ETC_ACT_TOGGLE 2'h1
`define ETC_ACT_CLEAR 2'h2
`define ETC_ACT_SET 2'h3
`define ETC_F_OVF 0
`define ETC_F_MA 1
`define ETC_F_MB 2
`define ETC_B_WGM2 3
`define ETC_B_FOCB 6
`define ETC_B_FOCA 7
`endif

// file: hdl/etc_pkg.sv
package etc_pkg;
	typedef struct packed {
		logic [7:0] count;
		logic [7:0] cmp_a;
		logic [7:0] cmp_b;
		logic [7:0] buf_a;
		logic [7:0] buf_b;
		logic [7:0] ctrl_a;
		logic [3:0] ctrl_b;
		logic [2:0] mask;
		logic [2:0] flags;
		logic power_off;
		logic block;
		logic [1:0] wave;
		logic [7:0] rdata;
		logic [2:0] irq;
		logic at_bottom;
		logic pin_s1;
		logic pin_s2;
		logic pin_d;
	} etc_state_t;
endpackage

// file: hdl/etc_timer.sv
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "etc_regs.svh"
module etc_timer import etc_pkg::*; (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic PRESCALE_TICK,
	input wire logic EXT_COUNT_PIN,
	input wire logic [2:0] IRQ_ACK,
	output logic [7:0] RDATA,
	output logic [2:0] IRQ,
	output logic WAVE_OUT_A,
	output logic WAVE_OUT_B,
	output logic AT_BOTTOM
);
	etc_state_t s;
	etc_state_t next_s;
	logic [2:0] mode;
	logic [2:0] cs;
	logic tick;
	logic pwm;
	logic [7:0] top;
	logic match_a;
	logic match_b;
	logic [2:0] hw_set;
	logic [2:0] sw_clr;
	logic [7:0] cnt_nx;
	logic [1:0] act_a;
	logic [1:0] act_b;

	// ****************************************
	// output action of a match
	// ****************************************
	function automatic logic act_out(input logic [1:0] act, input logic cur, input logic p);
		logic r;
		r = cur;
		if (act == `ETC_ACT_TOGGLE && !p) begin
			r = ~cur;
		end else if (act == `ETC_ACT_CLEAR) begin
			r = 1'b0;
		end else if (act == `ETC_ACT_SET) begin
			r = 1'b1;
		end
		return r;
	endfunction

	// ****************************************
	// decode and tick
	// ****************************************
	assign mode = {s.ctrl_b[`ETC_B_WGM2], s.ctrl_a[1:0]};
	assign cs = s.ctrl_b[2:0];
	assign act_a = s.ctrl_a[7:6];
	assign act_b = s.ctrl_a[5:4];
	assign pwm = s.ctrl_a[0];
	assign top = (mode == `ETC_M_FAST_A || mode == `ETC_M_CTC) ? s.cmp_a : `ETC_MAX;

	always_comb begin
		tick = 1'b0;
		if (s.power_off || cs == `ETC_CS_OFF) begin
			tick = 1'b0;
		end else if (cs == `ETC_CS_FALL) begin
			tick = s.pin_d & ~s.pin_s2;
		end else if (cs == `ETC_CS_RISE) begin
			tick = ~s.pin_d & s.pin_s2;
		end else begin
			tick = PRESCALE_TICK;
		end
	end

	assign match_a = (s.count == s.cmp_a) && !s.block;
	assign match_b = (s.count == s.cmp_b) && !s.block;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_s = s;
		next_s.pin_s1 = EXT_COUNT_PIN;
		next_s.pin_s2 = s.pin_s1;
		next_s.pin_d = s.pin_s2;
		hw_set = 3'h0;
		sw_clr = IRQ_ACK & s.flags;
		cnt_nx = s.count;
		if (tick) begin
			next_s.block = 1'b0;
			if ((mode == `ETC_M_CTC && match_a) || (pwm && s.count == top)) begin
				cnt_nx = `ETC_BOTTOM;
			end else begin
				cnt_nx = s.count + 8'h01;
			end
			if (s.count == `ETC_MAX && mode[1:0] != `ETC_M_PHASE_LO) begin
				hw_set[`ETC_F_OVF] = 1'b1;
			end
			if (mode == `ETC_M_FAST_A && s.count == top) begin
				hw_set[`ETC_F_OVF] = 1'b1;
			end
			hw_set[`ETC_F_MA] = match_a;
			hw_set[`ETC_F_MB] = match_b;
			if (match_a) begin
				next_s.wave[0] = act_out(act_a, s.wave[0], pwm);
			end
			if (match_b) begin
				next_s.wave[1] = act_out(act_b, s.wave[1], pwm);
			end
			if (pwm && cnt_nx == `ETC_BOTTOM) begin
				if (act_a == `ETC_ACT_CLEAR) next_s.wave[0] = 1'b1;
				if (act_a == `ETC_ACT_SET) next_s.wave[0] = 1'b0;
				if (act_b == `ETC_ACT_CLEAR) next_s.wave[1] = 1'b1;
				if (act_b == `ETC_ACT_SET) next_s.wave[1] = 1'b0;
			end
			if (pwm && s.count == top) begin
				next_s.cmp_a = s.buf_a;
				next_s.cmp_b = s.buf_b;
			end
		end
		next_s.count = cnt_nx;
		next_s.at_bottom = (cnt_nx == `ETC_BOTTOM);
		if (WR) begin
			if (ADDR == `ETC_A_CTRL_A) begin
				next_s.ctrl_a = WDATA;
			end else if (ADDR == `ETC_A_CTRL_B) begin
				next_s.ctrl_b = WDATA[3:0];
				if (!pwm && WDATA[`ETC_B_FOCA]) begin
					next_s.wave[0] = act_out(act_a, s.wave[0], 1'b0);
				end
				if (!pwm && WDATA[`ETC_B_FOCB]) begin
					next_s.wave[1] = act_out(act_b, s.wave[1], 1'b0);
				end
			end else if (ADDR == `ETC_A_COUNT) begin
				next_s.count = WDATA;
				next_s.at_bottom = (WDATA == `ETC_BOTTOM);
				next_s.block = 1'b1;
			end else if (ADDR == `ETC_A_CMP_A) begin
				next_s.buf_a = WDATA;
				if (!pwm) next_s.cmp_a = WDATA;
			end else if (ADDR == `ETC_A_CMP_B) begin
				next_s.buf_b = WDATA;
				if (!pwm) next_s.cmp_b = WDATA;
			end else if (ADDR == `ETC_A_MASK) begin
				next_s.mask = WDATA[2:0];
			end else if (ADDR == `ETC_A_FLAGS) begin
				sw_clr = sw_clr | WDATA[2:0];
			end else if (ADDR == `ETC_A_POWER) begin
				next_s.power_off = WDATA[0];
			end
		end
		next_s.flags = (s.flags & ~sw_clr) | hw_set;
		next_s.irq = next_s.flags & next_s.mask;
		next_s.rdata = `ETC_ZERO8;
		if (RD) begin
			if (ADDR == `ETC_A_CTRL_A) begin
				next_s.rdata = s.ctrl_a;
			end else if (ADDR == `ETC_A_CTRL_B) begin
				next_s.rdata = {4'h0, s.ctrl_b};
			end else if (ADDR == `ETC_A_COUNT) begin
				next_s.rdata = s.count;
			end else if (ADDR == `ETC_A_CMP_A) begin
				next_s.rdata = pwm ? s.buf_a : s.cmp_a;
			end else if (ADDR == `ETC_A_CMP_B) begin
				next_s.rdata = pwm ? s.buf_b : s.cmp_b;
			end else if (ADDR == `ETC_A_MASK) begin
				next_s.rdata = {5'h00, s.mask};
			end else if (ADDR == `ETC_A_FLAGS) begin
				next_s.rdata = {5'h00, s.flags};
			end else if (ADDR == `ETC_A_POWER) begin
				next_s.rdata = {7'h00, s.power_off};
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			s <= '0;
			s.power_off <= 1'b1;
			s.at_bottom <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign RDATA = s.rdata;
	assign IRQ = s.irq;
	assign WAVE_OUT_A = s.wave[0];
	assign WAVE_OUT_B = s.wave[1];
	assign AT_BOTTOM = s.at_bottom;

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	a_stop_holds: assert property (cs == `ETC_CS_OFF && !WR |=> s.count == $past(s.count))
		else $error("counter moved while stopped");
	a_write_wins: assert property (WR && ADDR == `ETC_A_COUNT |=> s.count == $past(WDATA))
		else $error("counter write lost");
	a_block_match: assert property (s.block && tick |=> !s.flags[`ETC_F_MA] || $past(s.flags[`ETC_F_MA]))
		else $error("match not blocked after counter write");
	a_block_set: assert property (WR && ADDR == `ETC_A_COUNT |=> s.block)
		else $error("counter write did not arm blocking");
	a_match_flag: assert property (tick && match_a |=> s.flags[`ETC_F_MA])
		else $error("match flag not set");
	a_set_wins: assert property (hw_set[`ETC_F_OVF] |=> s.flags[`ETC_F_OVF])
		else $error("overflow set lost");
	a_irq_mask: assert property (##1 IRQ == (s.flags & s.mask))
		else $error("request not gated by mask");
	a_power_off: assert property (s.power_off && !WR |=> s.count == $past(s.count))
		else $error("counter ran while powered off");
	a_wrap_ovf: assert property (tick && mode == `ETC_M_NORMAL && s.count == `ETC_MAX && !WR |=> s.count == `ETC_BOTTOM && s.flags[`ETC_F_OVF])
		else $error("normal wrap wrong");
	a_ctc_clear: assert property (tick && mode == `ETC_M_CTC && match_a && !WR |=> s.count == `ETC_BOTTOM)
		else $error("ctc clear missing");

	// ****************************************
	// buffering, restart, output and flag checks
	// ****************************************
	sequence s_top_tick;
		tick && pwm && s.count == top;
	endsequence
	sequence s_cmp_a_write;
		WR && ADDR == `ETC_A_CMP_A;
	endsequence

	a_buf_copy: assert property (s_top_tick |=> s.cmp_a == $past(s.buf_a))
		else $error("buffer not copied at top");
	a_fast_clear: assert property (s_top_tick ##0 !WR |=> s.count == `ETC_BOTTOM)
		else $error("fast pwm did not restart at top");
	a_cmp_direct: assert property (s_cmp_a_write ##0 !pwm |=> s.cmp_a == $past(WDATA))
		else $error("compare write not direct");
	a_cmp_buffered: assert property (s_cmp_a_write ##0 (pwm && !(tick && s.count == top)) |=> s.cmp_a == $past(s.cmp_a))
		else $error("active compare changed outside top");
	a_force_noflag: assert property (WR && ADDR == `ETC_A_CTRL_B && !tick |=> !s.flags[`ETC_F_MA] || $past(s.flags[`ETC_F_MA]))
		else $error("force set a flag");
	a_action_none: assert property (tick && match_a && act_a == `ETC_ACT_NONE && !pwm && !WR |=> WAVE_OUT_A == $past(WAVE_OUT_A))
		else $error("action zero changed output");
	a_flag_clear: assert property (WR && ADDR == `ETC_A_FLAGS && WDATA[`ETC_F_MA] && !(tick && match_a) |=> !s.flags[`ETC_F_MA])
		else $error("write one did not clear flag");
endmodule

// file: testbench/etc_timer_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module etc_timer_tb;
	typedef struct packed {
		logic [3:0] a;
		logic [7:0] w;
		logic [7:0] e;
	} etc_row_t;
	logic CLK_SYS = 1'b0;
	logic RST = 1'b1;
	logic [3:0] ADDR = 4'h0;
	logic [7:0] WDATA = 8'h00;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic PRESCALE_TICK = 1'b0;
	logic EXT_COUNT_PIN = 1'b0;
	logic [2:0] IRQ_ACK = 3'h0;
	logic [7:0] RDATA;
	logic [2:0] IRQ;
	logic WAVE_OUT_A;
	logic WAVE_OUT_B;
	logic AT_BOTTOM;
	int n_fail = 0;
	int checked = 0;
	etc_row_t rows [5] = '{'{4'h2, 8'h5a, 8'h5a}, '{4'h3, 8'h12, 8'h12},
		'{4'h4, 8'h34, 8'h34}, '{4'h5, 8'h01, 8'h01}, '{4'h9, 8'hff, 8'h00}};
	etc_timer etc_timer_i (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .PRESCALE_TICK(PRESCALE_TICK), .EXT_COUNT_PIN(EXT_COUNT_PIN),
		.IRQ_ACK(IRQ_ACK), .RDATA(RDATA), .IRQ(IRQ), .WAVE_OUT_A(WAVE_OUT_A),
		.WAVE_OUT_B(WAVE_OUT_B), .AT_BOTTOM(AT_BOTTOM));
	always #50 CLK_SYS = ~CLK_SYS;
	// ****************************************
	// bus and tick tasks
	// ****************************************
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge CLK_SYS);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK_SYS);
		WR <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		@(posedge CLK_SYS);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK_SYS);
		RD <= 1'b0;
		@(negedge CLK_SYS);
		`CHK(RDATA, e)
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge CLK_SYS);
			PRESCALE_TICK <= 1'b1;
			@(posedge CLK_SYS);
			PRESCALE_TICK <= 1'b0;
			repeat (3) @(posedge CLK_SYS);
		end
		@(negedge CLK_SYS);
	endtask
	task automatic pin_pulse();
		@(posedge CLK_SYS);
		EXT_COUNT_PIN <= 1'b1;
		repeat (4) @(posedge CLK_SYS);
		EXT_COUNT_PIN <= 1'b0;
		repeat (4) @(posedge CLK_SYS);
	endtask
	task automatic results();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ****************************************
	// tests
	// ****************************************
	initial begin
		repeat (20) @(posedge CLK_SYS);
		RST <= 1'b0;
		rchk(4'h7, 8'h01);
		rchk(4'h2, 8'h00);
		`CHK(AT_BOTTOM, 1'b1)
		wr(4'h7, 8'h00);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rchk(rows[i].a, rows[i].e);
		end
		tick(2);
		rchk(4'h2, 8'h5a);
		wr(4'h2, 8'hff);
		wr(4'h1, 8'h01);
		tick(1);
		rchk(4'h2, 8'h00);
		`CHK(AT_BOTTOM, 1'b1)
		rchk(4'h6, 8'h01);
		`CHK(IRQ, 3'h1)
		@(posedge CLK_SYS);
		IRQ_ACK <= 3'h1;
		@(posedge CLK_SYS);
		IRQ_ACK <= 3'h0;
		repeat (2) @(posedge CLK_SYS);
		@(negedge CLK_SYS);
		`CHK(IRQ, 3'h0)
		wr(4'h3, 8'h03);
		wr(4'h2, 8'h03);
		tick(1);
		rchk(4'h6, 8'h00);
		wr(4'h2, 8'h02);
		tick(3);
		rchk(4'h6, 8'h02);
		`CHK(IRQ, 3'h0)
		`CHK(WAVE_OUT_A, 1'b0)
		wr(4'h6, 8'h02);
		rchk(4'h6, 8'h00);
		wr(4'h0, 8'h40);
		wr(4'h1, 8'h81);
		repeat (2) @(posedge CLK_SYS);
		@(negedge CLK_SYS);
		`CHK(WAVE_OUT_A, 1'b1)
		rchk(4'h6, 8'h00);
		wr(4'h0, 8'h02);
		`CHK(WAVE_OUT_A, 1'b1)
		wr(4'h2, 8'h00);
		tick(4);
		rchk(4'h2, 8'h00);
		wr(4'h1, 8'h07);
		pin_pulse();
		rchk(4'h2, 8'h01);
		wr(4'h1, 8'h06);
		pin_pulse();
		rchk(4'h2, 8'h02);
		wr(4'h0, 8'hc3);
		wr(4'h3, 8'h05);
		rchk(4'h3, 8'h05);
		wr(4'h2, 8'hfe);
		wr(4'h1, 8'h01);
		tick(2);
		`CHK(WAVE_OUT_A, 1'b0)
		rchk(4'h2, 8'h00);
		wr(4'h6, 8'h07);
		tick(4);
		rchk(4'h6, 8'h00);
		tick(2);
		rchk(4'h6, 8'h02);
		`CHK(WAVE_OUT_A, 1'b1)
		wr(4'h0, 8'h30);
		wr(4'h1, 8'h40);
		@(negedge CLK_SYS);
		`CHK(WAVE_OUT_B, 1'b1)
		@(posedge CLK_SYS);
		RST <= 1'b1;
		@(posedge CLK_SYS);
		RST <= 1'b0;
		rchk(4'h7, 8'h01);
		rchk(4'h2, 8'h00);
		`CHK(AT_BOTTOM, 1'b1)
		`CHK(WAVE_OUT_A, 1'b0)
		`CHK(WAVE_OUT_B, 1'b0)
		results();
	end
	initial begin
		repeat (5000) @(posedge CLK_SYS);
		n_fail++;
		results();
	end
endmodule
